// ---- src/plc_top.sv ----
// pixel lookup table with computed offset, gain, gamma and negate
//
// Overview of operation
// (RULE_01) full table, every entry software writable
// (RULE_02) table is linear unless reprogrammed
// (RULE_03) fourteen bit table index
// (RULE_04) sixteen bit entries and results
// (RULE_05) settings regenerate table only in computed mode
// (RULE_06) order: offset, gain, gamma, then negate
// (RULE_07) offset spans -1.0 to +1.0, resets 0.0
// (RULE_08) gain spans 0 to 16384.0, resets 1.0
// (RULE_09) gamma spans -1000.0 to 1000.0, resets 1.0
// (RULE_10) entry is (gain*(x/max+offset))^(1/gamma) scaled
// (RULE_11) negate gives full scale minus entry
// (RULE_12) results clamp to zero and full scale
// (RULE_13) one table per component, shared settings
// (RULE_14) identity settings give a scaled passthrough
// (RULE_15) offset is relative to full scale
// (RULE_16) negate is on/off, resets off
// (RULE_17) read-only implementation kind, complete table
// (RULE_18) read-only index and result depths
// (RULE_19) direct writes and regenerations replace each other
// (RULE_20) one pixel per cycle, fixed latency, no stall
`timescale 1ns/1ps
`default_nettype none
module plc_top #(
  parameter int IDX_W = plc_pkg::IDX_W,
  parameter int RES_W = plc_pkg::RES_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic pix_in_valid,
  input wire logic [1:0] pix_in_comp,
  input wire logic [IDX_W-1:0] pix_in_value,
  output logic pix_out_valid,
  output logic [1:0] pix_out_comp,
  output logic [RES_W-1:0] pix_out_value
);
  localparam logic [IDX_W-1:0] IDX_LAST = '1;
  localparam logic [RES_W-1:0] RES_FULL = '1;

  typedef struct packed {
    logic rd_pend;
    logic [31:0] rdata;
    logic src_comp;
    logic negate;
    logic signed [17:0] offset;
    logic [30:0] gain;
    logic signed [23:0] gamma;
    logic [IDX_W-1:0] tbl_idx;
    logic [1:0] tbl_comp;
    plc_pkg::plc_state_e st;
    logic regen;
    logic [IDX_W-1:0] idx;
    logic [4:0] cnt;
    logic [24:0] rem;
    logic [24:0] quot;
    logic signed [26:0] recip;
    logic [32:0] v;
    logic zf;
    logic signed [21:0] l;
    logic signed [48:0] t;
    logic vld1;
    logic [1:0] comp1;
    logic out_vld;
    logic [1:0] out_comp;
    logic [RES_W-1:0] out_pix;
  } plc_state_s;

  plc_state_s r;
  plc_state_s next_r;

  // table selector: code 3 reads table 0, but writes all tables
  function automatic logic [1:0] comp_sel(input logic [1:0] c);
    comp_sel = (c == 2'h3) ? 2'h0 : c;
  endfunction : comp_sel

  // write enable of one table: code 3 hits every table at once
  function automatic logic comp_hit(input logic [1:0] c, input int k);
    comp_hit = (c == 2'h3) || (c == 2'(k));
  endfunction : comp_hit

  // position of the leading one, zero when v is zero
  function automatic logic [5:0] lead_pos(input logic [32:0] v);
    lead_pos = 6'h00;
    for (int i = 0; i < 33; i++) begin
      if (v[i]) begin
        lead_pos = 6'(i);
      end
    end
  endfunction : lead_pos

  // apb decode
  logic setup;
  logic access;
  logic is_data;
  logic mapped;
  logic gen_we;
  logic apb_we;
  logic [RES_W-1:0] gen_wd;
  logic [RES_W-1:0] rd_stream [plc_pkg::COMPS];
  logic [RES_W-1:0] rd_apb [plc_pkg::COMPS];

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign is_data = (paddr == plc_pkg::ADDR_TBL_DATA);
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= plc_pkg::ADDR_PROPS);
  assign gen_we = (r.st == plc_pkg::ST_WRITE);
  // data reads wait one cycle for the table; data writes yield to generator
  assign pready = !(is_data && !pwrite && !r.rd_pend) &&
                  !(is_data && pwrite && gen_we);
  assign pslverr = access && !mapped;
  assign prdata = r.rdata;
  assign apb_we = access && pready && pwrite && is_data; // [RULE_01] [RULE_19]
  assign pix_out_valid = r.out_vld;
  assign pix_out_comp = r.out_comp;
  assign pix_out_value = r.out_pix;

  // result of the exp2 step, clamped and optionally negated
  always_comb begin
    logic signed [48:0] ip;
    logic [16:0] y;
    logic [32:0] sc;
    logic [RES_W-1:0] res;
    ip = r.t >>> 16;
    y = 17'h00000;
    sc = '0;
    res = '0;
    if (r.zf) begin
      // 0^(1/gamma): zero for positive gamma, full scale otherwise
      res = (r.recip > 0) ? '0 : RES_FULL; // [RULE_12]
    end else if (r.t >= 0) begin
      res = RES_FULL; // [RULE_12]
    end else if (ip < -49'sd17) begin
      res = '0; // [RULE_12]
    end else begin
      y = {1'b1, r.t[15:0]} >> 6'(-ip);
      sc = (33'(y) * 33'(RES_FULL)) + 33'h8000; // [RULE_04] [RULE_14]
      res = sc[16 +: RES_W];
    end
    gen_wd = r.negate ? (RES_FULL - res) : res; // [RULE_11] [RULE_06]
  end

  // next state: register file, generator and stream pipeline
  always_comb begin
    logic [24:0] r2;
    logic signed [18:0] xn;
    logic signed [18:0] sum;
    logic [48:0] prod;
    logic [5:0] pos;
    logic [32:0] mant;
    logic signed [23:0] wg;
    logic signed [17:0] wo;
    logic cfg_wr;
    r2 = '0;
    xn = '0;
    sum = '0;
    prod = '0;
    pos = '0;
    mant = '0;
    wg = '0;
    wo = '0;
    cfg_wr = 1'b0;
    next_r = r;

    // register read data is captured in the setup cycle
    if (setup) begin
      case (paddr)
        plc_pkg::ADDR_CTRL: begin
          next_r.rdata = 32'(r.src_comp) << plc_pkg::CTRL_SRC_BIT;
          next_r.rdata[plc_pkg::CTRL_NEG_BIT] = r.negate;
        end
        plc_pkg::ADDR_OFFSET: next_r.rdata = 32'(signed'(r.offset));
        plc_pkg::ADDR_GAIN: next_r.rdata = 32'(r.gain);
        plc_pkg::ADDR_GAMMA: next_r.rdata = 32'(signed'(r.gamma));
        plc_pkg::ADDR_TBL_SEL: begin
          next_r.rdata = 32'(r.tbl_idx);
          next_r.rdata[plc_pkg::SEL_COMP_LSB +: 2] = r.tbl_comp;
        end
        plc_pkg::ADDR_STATUS: begin
          next_r.rdata = 32'(r.st != plc_pkg::ST_IDLE);
        end
        plc_pkg::ADDR_PROPS: begin
          next_r.rdata = '0;
          next_r.rdata[plc_pkg::PROP_KIND_LSB +: 2] =
            plc_pkg::KIND_COMPLETE; // [RULE_17]
          next_r.rdata[plc_pkg::PROP_IDX_LSB +: 5] = 5'(IDX_W); // [RULE_18]
          next_r.rdata[plc_pkg::PROP_RES_LSB +: 5] = 5'(RES_W); // [RULE_18]
        end
        default: next_r.rdata = '0;
      endcase
    end
    // table read: entry is valid one cycle after the selector settled
    if (access && is_data && !pwrite && !r.rd_pend) begin
      next_r.rd_pend = 1'b1;
      next_r.rdata = 32'(rd_apb[comp_sel(r.tbl_comp)]);
    end
    if (access && pready) begin
      next_r.rd_pend = 1'b0;
    end

    // register writes take effect at the completing access edge
    if (access && pready && pwrite) begin
      case (paddr)
        plc_pkg::ADDR_CTRL: begin
          next_r.src_comp = pwdata[plc_pkg::CTRL_SRC_BIT];
          next_r.negate = pwdata[plc_pkg::CTRL_NEG_BIT]; // [RULE_16]
          cfg_wr = 1'b1;
        end
        plc_pkg::ADDR_OFFSET: begin
          wo = pwdata[17:0];
          if (signed'(pwdata) > 32'(plc_pkg::OFFSET_MAX)) begin
            wo = plc_pkg::OFFSET_MAX; // [RULE_07]
          end else if (signed'(pwdata) < 32'(plc_pkg::OFFSET_MIN)) begin
            wo = plc_pkg::OFFSET_MIN; // [RULE_07]
          end
          next_r.offset = wo;
          cfg_wr = 1'b1;
        end
        plc_pkg::ADDR_GAIN: begin
          next_r.gain = (pwdata[30:0] > plc_pkg::GAIN_MAX || pwdata[31]) ?
                        plc_pkg::GAIN_MAX : pwdata[30:0]; // [RULE_08]
          cfg_wr = 1'b1;
        end
        plc_pkg::ADDR_GAMMA: begin
          wg = pwdata[23:0];
          if (signed'(pwdata) > 32'(plc_pkg::GAMMA_MAX)) begin
            wg = plc_pkg::GAMMA_MAX; // [RULE_09]
          end else if (signed'(pwdata) < 32'(plc_pkg::GAMMA_MIN)) begin
            wg = plc_pkg::GAMMA_MIN; // [RULE_09]
          end
          next_r.gamma = wg;
          cfg_wr = 1'b1;
        end
        plc_pkg::ADDR_TBL_SEL: begin
          next_r.tbl_idx = pwdata[IDX_W-1:0];
          next_r.tbl_comp = pwdata[plc_pkg::SEL_COMP_LSB +: 2];
        end
        default: begin
        end
      endcase
    end
    // generator: one reciprocal per run, then one entry every four cycles
    case (r.st)
      plc_pkg::ST_IDLE: begin
        if (r.regen) begin
          next_r.regen = 1'b0;
          next_r.st = plc_pkg::ST_RECIP;
          next_r.cnt = '0;
          next_r.rem = '0;
          next_r.quot = '0;
        end
      end
      plc_pkg::ST_RECIP: begin
        // restoring divide of 2^24 by |gamma| gives 1/gamma in q.12
        r2 = {r.rem[23:0], (r.cnt == 5'h00)};
        if (r2 >= 25'(r.gamma < 0 ? -r.gamma : r.gamma) && r.gamma != 0) begin
          next_r.rem = r2 - 25'(r.gamma < 0 ? -r.gamma : r.gamma);
          next_r.quot = {r.quot[23:0], 1'b1};
        end else begin
          next_r.rem = r2;
          next_r.quot = {r.quot[23:0], 1'b0};
        end
        next_r.cnt = r.cnt + 5'h01;
        if (r.cnt == plc_pkg::DIV_STEPS - 5'h01) begin
          next_r.recip = (r.gamma < 0) ? -27'(next_r.quot) :
                         27'(next_r.quot); // [RULE_10]
          next_r.st = plc_pkg::ST_SUM;
          next_r.idx = '0;
        end
      end
      plc_pkg::ST_SUM: begin
        // offset first, relative to full scale, then gain
        xn = 19'((19'(r.idx) << (16 - IDX_W)) +
                 (19'(r.idx) >> (2 * IDX_W - 16))); // [RULE_03] [RULE_15]
        sum = xn + 19'(r.offset); // [RULE_06] [RULE_15]
        prod = (sum > 0) ? 49'(r.gain) * 49'(sum) : '0; // [RULE_06]
        next_r.v = prod[48:16];
        next_r.st = plc_pkg::ST_LOG;
      end
      plc_pkg::ST_LOG: begin
        // piecewise linear log2; exp2 below inverts it exactly
        pos = lead_pos(r.v);
        mant = r.v << (6'd32 - pos);
        next_r.zf = (r.v == '0);
        next_r.l = 22'((22'(pos) - 22'sd16) <<< 16) + 22'(mant[31:16]);
        next_r.st = plc_pkg::ST_EXP;
      end
      plc_pkg::ST_EXP: begin
        // t is log2 of the corrected value scaled by 1/gamma, in q.16
        next_r.t = (49'(r.l) * 49'(r.recip)) >>> 12; // [RULE_06] [RULE_10]
        next_r.st = plc_pkg::ST_WRITE;
      end
      plc_pkg::ST_WRITE: begin
        next_r.idx = r.idx + 1'b1;
        if (r.regen) begin
          // a newer setting restarts the run from the first entry
          next_r.regen = 1'b0;
          next_r.st = plc_pkg::ST_RECIP;
          next_r.cnt = '0;
          next_r.rem = '0;
          next_r.quot = '0;
        end else if (r.idx == IDX_LAST) begin
          next_r.st = plc_pkg::ST_IDLE;
        end else begin
          next_r.st = plc_pkg::ST_SUM;
        end
      end
      default: next_r.st = plc_pkg::ST_IDLE;
    endcase

    // only computed mode lets a setting change rebuild the tables;
    // placed after the generator so a new request beats the clear
    // of an older one in the same cycle
    if (cfg_wr && next_r.src_comp) begin
      next_r.regen = 1'b1; // [RULE_05] [RULE_19]
    end

    // stream: table read, then output register, two cycles in all
    next_r.vld1 = pix_in_valid; // [RULE_20]
    next_r.comp1 = pix_in_comp;
    next_r.out_vld = r.vld1;
    next_r.out_comp = r.comp1;
    next_r.out_pix = rd_stream[comp_sel(r.comp1)]; // [RULE_13] [RULE_20]
  end

  // after reset the generator fills the tables with the linear map
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.src_comp <= plc_pkg::CTRL_SRC_RST;
      r.negate <= plc_pkg::CTRL_NEG_RST; // [RULE_16]
      r.offset <= plc_pkg::OFFSET_RST; // [RULE_07]
      r.gain <= plc_pkg::GAIN_RST; // [RULE_08]
      r.gamma <= plc_pkg::GAMMA_RST; // [RULE_09]
      r.st <= plc_pkg::ST_RECIP; // [RULE_02] [RULE_14]
    end else begin
      r <= next_r;
    end
  end

  // one table per component; generator writes all with the same value
  for (genvar k = 0; k < plc_pkg::COMPS; k++) begin : g_tbl
    logic [RES_W-1:0] mem [2**IDX_W];
    always_ff @(posedge clk) begin
      if (gen_we) begin
        mem[r.idx] <= gen_wd; // [RULE_13] [RULE_19]
      end else if (apb_we && comp_hit(r.tbl_comp, k)) begin
        mem[r.tbl_idx] <= pwdata[RES_W-1:0]; // [RULE_01] [RULE_19]
      end
      rd_stream[k] <= mem[pix_in_value]; // [RULE_03] [RULE_20]
      rd_apb[k] <= mem[r.tbl_idx];
    end
  end : g_tbl
endmodule : plc_top
`default_nettype wire

// ---- inc/plc_pkg.sv ----
// constants, state codes and register map of the pixel lookup correction
package plc_pkg;
  // table geometry
  localparam int IDX_W = 14;
  localparam int RES_W = 16;
  localparam int COMPS = 3;
  // apb register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OFFSET = 8'h04;
  localparam logic [7:0] ADDR_GAIN = 8'h08;
  localparam logic [7:0] ADDR_GAMMA = 8'h0c;
  localparam logic [7:0] ADDR_TBL_SEL = 8'h10;
  localparam logic [7:0] ADDR_TBL_DATA = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_PROPS = 8'h1c;
  // field positions
  localparam int CTRL_SRC_BIT = 0;
  localparam int CTRL_NEG_BIT = 1;
  localparam int SEL_COMP_LSB = 16;
  localparam int PROP_KIND_LSB = 0;
  localparam int PROP_IDX_LSB = 8;
  localparam int PROP_RES_LSB = 16;
  // values after reset: computed source, no negate, identity corrections
  localparam logic CTRL_SRC_RST = 1'b1;
  localparam logic CTRL_NEG_RST = 1'b0;
  localparam logic [17:0] OFFSET_RST = 18'h00000;
  localparam logic [30:0] GAIN_RST = 31'h00010000;
  localparam logic [23:0] GAMMA_RST = 24'h001000;
  // setting limits: offset q1.16, gain q15.16, gamma q11.12
  localparam logic signed [17:0] OFFSET_MAX = 18'sh10000;
  localparam logic signed [17:0] OFFSET_MIN = -18'sh10000;
  localparam logic [30:0] GAIN_MAX = 31'h40000000;
  localparam logic signed [23:0] GAMMA_MAX = 24'sh3e8000;
  localparam logic signed [23:0] GAMMA_MIN = -24'sh3e8000;
  // implementation kinds
  localparam logic [1:0] KIND_COMPLETE = 2'h0;
  localparam logic [1:0] KIND_KNEE = 2'h1;
  // steps of the reciprocal divider (dividend is 2^24)
  localparam logic [4:0] DIV_STEPS = 5'h19;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RECIP = 3'b001,
    ST_SUM = 3'b010,
    ST_LOG = 3'b011,
    ST_EXP = 3'b100,
    ST_WRITE = 3'b101
  } plc_state_e;
endpackage : plc_pkg

// ---- bench/plc_checker.sv ----
// port assertions of the pixel lookup correction
`timescale 1ns/1ps
`default_nettype none
module plc_checker #(
  parameter int IDX_W = 14,
  parameter int RES_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic pix_in_valid,
  input wire logic [1:0] pix_in_comp,
  input wire logic [IDX_W-1:0] pix_in_value,
  input wire logic pix_out_valid,
  input wire logic [1:0] pix_out_comp,
  input wire logic [RES_W-1:0] pix_out_value
);
  default clocking dck @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a finished bus transfer, and a finished read of the properties word
  sequence s_done;
    psel && penable && pready;
  endsequence
  sequence s_rd_props;
    s_done ##0 (!pwrite && paddr == plc_pkg::ADDR_PROPS);
  endsequence
  property p_lat_valid;
    pix_in_valid |-> ##2 pix_out_valid;
  endproperty
  property p_lat_comp;
    pix_in_valid |-> ##2 (pix_out_comp == $past(pix_in_comp, 2));
  endproperty
  property p_no_extra;
    !pix_in_valid |-> ##2 !pix_out_valid;
  endproperty
  property p_err_phase;
    pslverr |-> psel && penable;
  endproperty
  property p_err_map;
    psel && penable && (paddr > plc_pkg::ADDR_PROPS || paddr[1:0] != 2'h0)
      |-> pslverr;
  endproperty
  property p_err_zero;
    s_done ##0 (pslverr && !pwrite) |-> prdata == 32'h0;
  endproperty
  property p_kind;
    s_rd_props |-> prdata[1:0] == plc_pkg::KIND_COMPLETE;
  endproperty
  property p_depth;
    s_rd_props |-> prdata[12:8] == 5'h0e && prdata[20:16] == 5'h10;
  endproperty
  // a table access never waits more than one cycle
  property p_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_lat_valid: assert property (p_lat_valid)
    else $error("stream output valid missing two cycles after input");
  a_lat_comp: assert property (p_lat_comp)
    else $error("stream output component differs from input");
  a_no_extra: assert property (p_no_extra)
    else $error("stream output valid without an input");
  a_err_phase: assert property (p_err_phase)
    else $error("slave error outside the access phase");
  a_err_map: assert property (p_err_map)
    else $error("unmapped address not refused");
  a_err_zero: assert property (p_err_zero)
    else $error("refused read returned nonzero data");
  a_kind: assert property (p_kind)
    else $error("implementation kind is not the complete table");
  a_depth: assert property (p_depth)
    else $error("reported index or result depth wrong");
  a_wait: assert property (p_wait)
    else $error("bus access waited more than one cycle");
endmodule : plc_checker
bind plc_top plc_checker #(.IDX_W(IDX_W), .RES_W(RES_W)) u_plc_checker (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .pix_in_valid(pix_in_valid),
  .pix_in_comp(pix_in_comp), .pix_in_value(pix_in_value),
  .pix_out_valid(pix_out_valid), .pix_out_comp(pix_out_comp),
  .pix_out_value(pix_out_value));
`default_nettype wire

// ---- bench/plc_pix_model.sv ----
// upstream pixel source and downstream result sink around the table
`timescale 1ns/1ps
`default_nettype none
module plc_pix_model (
  input wire logic clk,
  input wire logic rst_n,
  output logic pix_in_valid,
  output logic [1:0] pix_in_comp,
  output logic [13:0] pix_in_value,
  input wire logic pix_out_valid,
  input wire logic [1:0] pix_out_comp,
  input wire logic [15:0] pix_out_value
);
  logic [15:0] tx_q[$];
  logic [17:0] rx_q[$];
  // one queued pixel per cycle; idle cycles toggle the payload so a
  // design that ignores valid sees garbage, not a stale pixel
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pix_in_valid <= 1'b0;
      pix_in_comp <= 2'h0;
      pix_in_value <= 14'h0000;
    end else if (tx_q.size() != 0) begin
      pix_in_valid <= 1'b1;
      {pix_in_comp, pix_in_value} <= tx_q.pop_front();
    end else begin
      pix_in_valid <= 1'b0;
      {pix_in_comp, pix_in_value} <= ~{pix_in_comp, pix_in_value};
    end
  end
  // collect every result in arrival order
  always @(posedge clk) begin
    if (rst_n && pix_out_valid === 1'b1) begin
      rx_q.push_back({pix_out_comp, pix_out_value});
    end
  end
endmodule : plc_pix_model
`default_nettype wire

// ---- bench/tb.sv ----
// self-checking testbench of the pixel lookup correction
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, pix_in_valid, pix_out_valid;
  logic [31:0] prdata, rd;
  logic [1:0] pix_in_comp, pix_out_comp;
  logic [13:0] pix_in_value;
  logic [15:0] pix_out_value;
  logic er;
  int n_fail = 0;
  int checks_done = 0;
  always #4 clk = ~clk;
  plc_top u_plc_top (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pix_in_valid(pix_in_valid), .pix_in_comp(pix_in_comp),
    .pix_in_value(pix_in_value), .pix_out_valid(pix_out_valid),
    .pix_out_comp(pix_out_comp), .pix_out_value(pix_out_value));
  plc_pix_model u_pix (.clk(clk), .rst_n(rst_n),
    .pix_in_valid(pix_in_valid), .pix_in_comp(pix_in_comp),
    .pix_in_value(pix_in_value), .pix_out_valid(pix_out_valid),
    .pix_out_comp(pix_out_comp), .pix_out_value(pix_out_value));
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // computed entries may be off by the generator's rounding
  task automatic chk_near(input string nm, input int e, logic [15:0] g);
    int d;
    d = int'(g) - e;
    checks_done++;
    if (^g === 1'bx || d > 2 || d < -2) begin
      n_fail++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_near
  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, logic [7:0] a, logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // a slave that never answers counts as a mismatch and ends the run
    if (pready !== 1'b1) begin
      n_fail++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rdc(input logic [7:0] a, logic [31:0] e, string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdc
  task automatic take(input logic [1:0] c, output logic [15:0] v);
    int n;
    logic [17:0] w;
    n = 0;
    w = 'x;
    while (u_pix.rx_q.size() == 0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (u_pix.rx_q.size() != 0) w = u_pix.rx_q.pop_front();
    chk("comp", {30'h0, c}, {30'h0, w[17:16]});
    v = w[15:0];
  endtask : take
  task automatic t_reset_vals;
    rdc(plc_pkg::ADDR_CTRL, 32'h1, "ctrl");
    rdc(plc_pkg::ADDR_OFFSET, 32'h0, "offset");
    rdc(plc_pkg::ADDR_GAIN, 32'h10000, "gain");
    rdc(plc_pkg::ADDR_GAMMA, 32'h1000, "gamma");
    apb(1'b1, plc_pkg::ADDR_PROPS, 32'hffffffff);
    rdc(plc_pkg::ADDR_PROPS, 32'h00100e00, "props");
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
  endtask : t_reset_vals
  // the first fill after reset is long; poll busy under a bound
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, plc_pkg::ADDR_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 30000);
    chk("busy", 32'h0, {31'h0, rd[0]});
  endtask : wait_idle
  task automatic t_identity;
    logic [13:0] xs[4];
    logic [15:0] v;
    xs = '{14'h0000, 14'h0001, 14'h1fff, 14'h3fff};
    foreach (xs[i]) for (int c = 0; c < 3; c++) begin
      u_pix.tx_q.push_back({c[1:0], xs[i]});
    end
    foreach (xs[i]) for (int c = 0; c < 3; c++) begin
      take(c[1:0], v);
      chk_near("entry", int'(xs[i]) * 65535 / 16383, v);
    end
  endtask : t_identity
  // settings are only stored, with clamping, outside the computed source
  task automatic t_stored;
    apb(1'b1, plc_pkg::ADDR_CTRL, 32'h2);
    apb(1'b1, plc_pkg::ADDR_GAIN, 32'h7fffffff);
    apb(1'b1, plc_pkg::ADDR_OFFSET, 32'h00020000);
    apb(1'b1, plc_pkg::ADDR_GAMMA, 32'h00500000);
    rdc(plc_pkg::ADDR_STATUS, 32'h0, "busy");
    rdc(plc_pkg::ADDR_GAIN, 32'h40000000, "gain");
    rdc(plc_pkg::ADDR_OFFSET, 32'h00010000, "offset");
    rdc(plc_pkg::ADDR_GAMMA, 32'h003e8000, "gamma");
    rdc(plc_pkg::ADDR_CTRL, 32'h2, "ctrl");
  endtask : t_stored
  task automatic t_direct;
    logic [15:0] v;
    apb(1'b1, plc_pkg::ADDR_TBL_SEL, 32'h00033fff);
    apb(1'b1, plc_pkg::ADDR_TBL_DATA, 32'h1234);
    apb(1'b1, plc_pkg::ADDR_TBL_SEL, 32'h00010005);
    apb(1'b1, plc_pkg::ADDR_TBL_DATA, 32'hbeef);
    u_pix.tx_q = '{16'h3fff, 16'hbfff, 16'h4005, 16'h0005};
    take(2'h0, v);
    chk("entry", 32'h1234, {16'h0, v});
    take(2'h2, v);
    chk("entry", 32'h1234, {16'h0, v});
    take(2'h1, v);
    chk("entry", 32'hbeef, {16'h0, v});
    take(2'h0, v);
    chk_near("entry", 20, v);
    apb(1'b1, plc_pkg::ADDR_TBL_SEL, 32'h00003fff);
    rdc(plc_pkg::ADDR_TBL_DATA, 32'h1234, "readback");
  endtask : t_direct
  // settings staged in stored mode, then computed runs; only the first
  // entries are checked, since a full fill is too long to repeat
  task automatic t_computed;
    logic [15:0] v;
    apb(1'b1, plc_pkg::ADDR_GAIN, 32'h00010000);
    apb(1'b1, plc_pkg::ADDR_OFFSET, 32'h00008000);
    apb(1'b1, plc_pkg::ADDR_GAMMA, 32'h00001000);
    apb(1'b1, plc_pkg::ADDR_CTRL, 32'h3);
    // 25 divide cycles, then four cycles per entry
    repeat (100) @(posedge clk);
    u_pix.tx_q = '{16'h0000, 16'h0004, 16'h4005};
    take(2'h0, v);
    chk_near("entry", 65535 - 32768, v);
    take(2'h0, v);
    chk_near("entry", 65535 - 32768 - 4 * 65535 / 16383, v);
    take(2'h1, v);
    chk_near("entry", 65535 - 32768 - 5 * 65535 / 16383, v);
    // gamma 0.5 squares the half-scale value before the negate
    apb(1'b1, plc_pkg::ADDR_GAMMA, 32'h00000800);
    repeat (100) @(posedge clk);
    u_pix.tx_q = '{16'h8000};
    take(2'h2, v);
    chk_near("entry", 65535 - 65535 / 4, v);
    rdc(plc_pkg::ADDR_STATUS, 32'h1, "busy");
  endtask : t_computed
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset_vals();
    wait_idle();
    t_identity();
    t_stored();
    t_direct();
    t_computed();
    test_done();
  end
  // watchdog sized for one full table fill plus the scenarios
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    test_done();
  end
endmodule : tb
`default_nettype wire
